/* host_model.sv */
// host side model: sample strobe and a steady audio sample
// assumes one clock; strobe comes every FS_DIV clocks
module host_model #(
  parameter int FS_DIV = 4
) (
  input  wire logic          clk,
  input  wire logic          nrst,
  output logic               fs_en,
  output logic signed [15:0] sample_in
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] div_r;

  // ----------------
  // sample strobe
  // ----------------
  // short period keeps full ramps and timeouts cheap to run
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_r <= 8'h00;
      fs_en <= 1'b0;
    end else begin
      div_r <= (div_r == 8'(FS_DIV - 1)) ? 8'h00 : div_r + 8'h01;
      fs_en <= (div_r == 8'h00);
    end
  end

  // fixed level keeps the expected output exact
  assign sample_in = 16'sh1357;
endmodule

/* playback_mute_output_ctrl.sv */
// playback path control: soft mute, beep and DAC routing, line
// output power states, speaker gain, level-control manual handover
// assumes all inputs synchronous to clk; fs_en one pulse per sample
//
// Notes on behaviour
// R01 - mute set: ramp to zero, 245 samples
// R02 - mute cleared: ramp back to unity
// R03 - early cancel reverses ramp within same time
// R04 - one monotonic step per sample
// R05 - host holds level settings while active
// R06 - host edits settings only when disabled
// R07 - host starts volume at or below reference
// R08 - manual volume after zero-cross timeout elapses
// R09 - host sets wait equal to timeout
// R10 - recommended recording level-control setup
// R11 - recommended playback level-control setup
// R12 - beep power bit powers beep path
// R13 - beep routed to speaker when selected
// R14 - beep routed to line output when selected
// R15 - DAC off line output when deselected
// R16 - both bits zero: line output down
// R17 - save bit forces power-save mode
// R18 - power one, save zero: active
// R19 - host pop-free power-up sequence
// R20 - host pop-free power-down sequence
// R21 - DAC always feeds speaker amplifier
// R22 - speaker gain 0/2/4/6 dB by code
`include "playback_mute_output_defs.svh"

module playback_mute_output_ctrl #(
  parameter int RAMP_STEPS = `MUTE_RAMP_FS,
  parameter int SAMPLE_W   = 16
) (
  input  wire logic                              clk,
  input  wire logic                              nrst,
  input  wire logic                              fs_en,
  input  wire logic                              soft_mute_ctl,
  input  wire logic signed [SAMPLE_W-1:0]        sample_in,
  input  wire playback_mute_output_pkg::out_ctl_s out_ctl,
  input  wire logic                              record_level_ctrl_en,
  input  wire logic                              playback_level_ctrl_en,
  input  wire logic [1:0]                        zero_cross_timeout_sel,
  output logic signed [SAMPLE_W-1:0]             sample_out_r,
  output logic [`MUTE_ATT_W-1:0]                 mute_att_r,
  output playback_mute_output_pkg::out_drive_s   out_drive_r,
  output logic                                   manual_volume_r
);
  import playback_mute_output_pkg::*;

  localparam int PROD_W = SAMPLE_W + `MUTE_ATT_W;
  localparam logic [`MUTE_ATT_W-1:0] ATT_UNITY = `MUTE_ATT_W'(RAMP_STEPS);
  // divisor held signed at product width so the quotient keeps its sign
  localparam logic signed [PROD_W-1:0] ATT_DIV = PROD_W'(RAMP_STEPS);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic lineout_state_e lo_decode(input logic pwr,
                                               input logic save);
    if (save) begin
      lo_decode = lo_save; // R17
    end else if (pwr) begin
      lo_decode = lo_active; // R18
    end else begin
      lo_decode = lo_off; // R16
    end
  endfunction

  function automatic logic [`ZC_CNT_W-1:0] zc_limit(input logic [1:0] s);
    zc_limit = `ZC_TIMEOUT_BASE << s;
  endfunction

  // ------------------------------------------------------------
  // soft mute
  // ------------------------------------------------------------
  logic [`MUTE_ATT_W-1:0] att_w;
  logic signed [PROD_W-1:0] prod_w;

  soft_mute_ramp #(
    .RAMP_STEPS (RAMP_STEPS)
  ) u_ramp (
    .clk           (clk),
    .nrst          (nrst),
    .fs_en         (fs_en),
    .soft_mute_ctl (soft_mute_ctl),
    .att_r         (att_w)
  );

  // linear scale by att/unity; truncation costs at most one lsb,
  // unity bypasses the divider and passes exactly
  assign prod_w = PROD_W'(sample_in) * PROD_W'($signed({1'b0, att_w}));

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_out_r <= '0;
      mute_att_r   <= ATT_UNITY;
    end else if (fs_en) begin
      mute_att_r <= att_w;
      if (att_w == ATT_UNITY) begin
        sample_out_r <= sample_in; // R02
      end else begin
        sample_out_r <= SAMPLE_W'(prod_w / ATT_DIV); // R01
      end
    end
  end

  // ------------------------------------------------------------
  // routing, power and gain
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_drive_r <= '{beep_powered: 1'b0, beep_to_speaker: 1'b0,
                       beep_to_lineout: 1'b0, dac_to_lineout: 1'b0,
                       dac_to_speaker: 1'b1, lineout_state: lo_off,
                       speaker_gain_db: 4'h0};
    end else begin
      out_drive_r.beep_powered    <= out_ctl.beep_power_ctl; // R12
      out_drive_r.beep_to_speaker <= out_ctl.beep_to_speaker_sel; // R13
      out_drive_r.beep_to_lineout <= out_ctl.beep_to_lineout_sel; // R14
      out_drive_r.dac_to_lineout  <= out_ctl.dac_to_lineout_sel; // R15
      out_drive_r.dac_to_speaker  <= 1'b1; // R21
      out_drive_r.lineout_state   <= lo_decode(
        out_ctl.lineout_power_ctl, out_ctl.lineout_save_ctl);
      out_drive_r.speaker_gain_db <= 4'(out_ctl.speaker_gain_field
                                    * `SPK_GAIN_STEP_DB); // R22
    end
  end

  // ------------------------------------------------------------
  // level control to manual handover
  // ------------------------------------------------------------
  logic                  lc_en_w;
  logic                  lc_en_d_r;
  logic                  zc_busy_r;
  logic [`ZC_CNT_W-1:0]  zc_cnt_r;

  assign lc_en_w = record_level_ctrl_en | playback_level_ctrl_en;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lc_en_d_r       <= 1'b0;
      zc_busy_r       <= 1'b0;
      zc_cnt_r        <= '0;
      manual_volume_r <= 1'b1;
    end else begin
      lc_en_d_r <= lc_en_w;
      if (lc_en_w) begin
        zc_busy_r       <= 1'b0;
        manual_volume_r <= 1'b0;
      end else if (lc_en_d_r) begin
        zc_busy_r <= 1'b1; // R08
        zc_cnt_r  <= '0;
      end else if (zc_busy_r && fs_en) begin
        if (zc_cnt_r == zc_limit(zero_cross_timeout_sel)
                        - `ZC_CNT_W'(1)) begin
          zc_busy_r       <= 1'b0;
          manual_volume_r <= 1'b1; // R08
        end else begin
          zc_cnt_r <= zc_cnt_r + `ZC_CNT_W'(1);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence lc_drop_s;
    !lc_en_w && $past(lc_en_w);
  endsequence

  // nrst in the antecedents: the release edge still loads reset values
  AST_LO_SAVE: assert property (@(posedge clk) disable iff (!nrst) // R17
    nrst && out_ctl.lineout_save_ctl
      |=> out_drive_r.lineout_state == lo_save)
    else $error("save bit did not force power save");

  AST_LO_ACTIVE: assert property (@(posedge clk) disable iff (!nrst) // R18
    nrst && out_ctl.lineout_power_ctl && !out_ctl.lineout_save_ctl
      |=> out_drive_r.lineout_state == lo_active)
    else $error("line output not active");

  AST_LO_OFF: assert property (@(posedge clk) disable iff (!nrst) // R16
    nrst && !out_ctl.lineout_power_ctl && !out_ctl.lineout_save_ctl
      |=> out_drive_r.lineout_state == lo_off)
    else $error("line output not off");

  AST_SPK_GAIN: assert property (@(posedge clk) disable iff (!nrst) // R22
    nrst && out_ctl.speaker_gain_field == 2'b11
      |=> out_drive_r.speaker_gain_db == 4'h6)
    else $error("speaker gain code wrong");

  AST_SPK_GAIN_LOW: assert property (@(posedge clk) disable iff (!nrst) // R22
    nrst && out_ctl.speaker_gain_field == 2'b01
      |=> out_drive_r.speaker_gain_db == 4'h2)
    else $error("speaker gain code wrong");

  AST_ROUTE: assert property (@(posedge clk) disable iff (!nrst) // R13 R14 R15
    nrst |=> out_drive_r.beep_to_speaker == $past(
      out_ctl.beep_to_speaker_sel)
      && out_drive_r.beep_to_lineout == $past(
      out_ctl.beep_to_lineout_sel)
      && out_drive_r.dac_to_lineout == $past(
      out_ctl.dac_to_lineout_sel))
    else $error("routing does not follow select bits");

  AST_BEEP_PWR: assert property (@(posedge clk) disable iff (!nrst) // R12
    nrst && out_ctl.beep_power_ctl |=> out_drive_r.beep_powered)
    else $error("beep path not powered");

  AST_DAC_SPK: assert property (@(posedge clk) disable iff (!nrst) // R21
    out_drive_r.dac_to_speaker)
    else $error("DAC not feeding speaker");

  AST_MANUAL_WAIT: assert property (@(posedge clk) disable iff (!nrst) // R08
    lc_drop_s ##0 !lc_en_w [*2] |-> !manual_volume_r)
    else $error("manual mode entered without timeout");

  AST_MANUAL_DROP: assert property (@(posedge clk) disable iff (!nrst) // R08
    nrst && lc_en_w |=> !manual_volume_r)
    else $error("manual mode kept under level control");

  AST_MUTE_PASS: assert property (@(posedge clk) disable iff (!nrst) // R02
    nrst && fs_en && att_w == ATT_UNITY
      |=> sample_out_r == $past(sample_in))
    else $error("unity gain did not pass sample");

  AST_MUTE_ZERO: assert property (@(posedge clk) disable iff (!nrst) // R01
    nrst && fs_en && att_w == `MUTE_ATT_ZERO
      |=> sample_out_r == '0)
    else $error("full mute did not silence sample");

endmodule

/* playback_mute_output_ctrl_test.sv */
// self-checking bench for the playback mute / output control block
// assumes host_model supplies the sample strobe and audio
module playback_mute_output_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  import playback_mute_output_pkg::*;

  typedef struct packed {logic [7:0] ctl; logic [10:0] exp;} row_s;

  logic               clk, nrst, fs_en, soft_mute_ctl;
  logic               rec_en, pb_en, manual;
  logic [1:0]         zc_sel;
  logic signed [15:0] sample_in, sample_out;
  logic [7:0]         att;
  out_ctl_s           out_ctl;
  out_drive_s         drive;
  int                 n_fail, checks_done;
  row_s               rows [10];

  host_model host (.clk(clk), .nrst(nrst), .fs_en(fs_en),
    .sample_in(sample_in));

  playback_mute_output_ctrl uut (
    .clk(clk), .nrst(nrst), .fs_en(fs_en), .soft_mute_ctl(soft_mute_ctl),
    .sample_in(sample_in), .out_ctl(out_ctl),
    .record_level_ctrl_en(rec_en), .playback_level_ctrl_en(pb_en),
    .zero_cross_timeout_sel(zc_sel), .sample_out_r(sample_out),
    .mute_att_r(att), .out_drive_r(drive), .manual_volume_r(manual));

  // ----------------
  // helpers
  // ----------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // counts strobes, then lets the registered outputs settle
  task automatic wait_fs(input int n);
    int seen;
    seen = 0;
    for (int i = 0; i < n * 8 && seen < n; i++) begin
      @(negedge clk);
      if (fs_en === 1'b1)
        seen++;
    end
    if (seen < n) begin
      n_fail++;
      close_out();
    end
    repeat (2) @(negedge clk);
  endtask

  // a full clock first: no race with the clock's first edge at time 0
  task automatic reset_check();
    @(posedge clk);
    @(negedge clk);
    check({8'h00, att}, 16'h00f5);
    check({5'h00, drive}, 16'h0040);
    check({15'h0, manual}, 16'h0001);
    check(sample_out, 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------
  // main sequence
  // ----------------
  initial begin
    n_fail = 0;
    checks_done = 0;
    nrst = 1'b0;
    soft_mute_ctl = 1'b0;
    rec_en = 1'b0;
    pb_en = 1'b0;
    zc_sel = 2'b00;
    out_ctl = '0;
    // pop-free up, then pop-free down, then each path and gain
    rows = '{'{8'h04, 11'h050}, '{8'h0c, 11'h050}, '{8'h08, 11'h060},
             '{8'h0c, 11'h050}, '{8'h04, 11'h050}, '{8'h00, 11'h040},
             '{8'h81, 11'h442}, '{8'h42, 11'h244}, '{8'h23, 11'h146},
             '{8'h10, 11'h0c0}};
    reset_check();
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk) out_ctl <= rows[i].ctl;
      repeat (2) @(negedge clk);
      check({5'h00, drive}, {5'h00, rows[i].exp});
    end
    $display("test routing done");
    @(posedge clk) soft_mute_ctl <= 1'b1;
    wait_fs(100);
    check({8'h00, att}, 16'h0092);
    check(sample_out, 16'h0b86);
    @(posedge clk) soft_mute_ctl <= 1'b0;
    wait_fs(100);
    check({8'h00, att}, 16'h00f4);
    wait_fs(2);
    check({8'h00, att}, 16'h00f5);
    @(posedge clk) soft_mute_ctl <= 1'b1;
    wait_fs(247);
    check({8'h00, att}, 16'h0000);
    check(sample_out, 16'h0000);
    @(posedge clk) soft_mute_ctl <= 1'b0;
    wait_fs(247);
    check({8'h00, att}, 16'h00f5);
    check(sample_out, 16'h1357);
    $display("test soft mute done");
    for (int s = 0; s < 4; s++) begin
      @(posedge clk) zc_sel <= 2'(s);
      @(posedge clk) begin
        rec_en <= s[0];
        pb_en <= ~s[0];
      end
      repeat (2) @(negedge clk);
      check({15'h0, manual}, 16'h0000);
      @(posedge clk) begin
        rec_en <= 1'b0;
        pb_en <= 1'b0;
      end
      wait_fs((128 << s) - 3);
      check({15'h0, manual}, 16'h0000);
      wait_fs(6);
      check({15'h0, manual}, 16'h0001);
    end
    $display("test manual handover done");
    // reset in mid-ramp must restore unity at once
    @(posedge clk) soft_mute_ctl <= 1'b1;
    wait_fs(50);
    @(posedge clk) nrst <= 1'b0;
    reset_check();
    @(posedge clk) begin
      nrst <= 1'b1;
      soft_mute_ctl <= 1'b0;
    end
    $display("test mid-run reset done");
    close_out();
  end
endmodule

/* playback_mute_output_defs.svh */
// constants for the playback mute / output control block
// assumes inclusion by the package and the design files only
`ifndef PLAYBACK_MUTE_OUTPUT_DEFS_SVH
`define PLAYBACK_MUTE_OUTPUT_DEFS_SVH

// soft mute ramp length in sample periods
`define MUTE_RAMP_FS      245
`define MUTE_ATT_W        8
`define MUTE_ATT_UNITY    8'hf5
`define MUTE_ATT_ZERO     8'h00
// zero-cross timeout base: 128/fs shifted by the 2-bit selector
`define ZC_TIMEOUT_BASE   11'h080
`define ZC_CNT_W          11
// line output state codes
`define LO_OFF            2'b00
`define LO_SAVE           2'b01
`define LO_ACTIVE         2'b10
// speaker gain step in dB per code, reset value of the gain code
`define SPK_GAIN_STEP_DB  4'h2
`define SPK_GAIN_RST      2'b00

`endif

/* playback_mute_output_pkg.sv */
// types shared by the playback mute / output control block
// assumes the defs header sits in the include path
`include "playback_mute_output_defs.svh"

package playback_mute_output_pkg;

  typedef enum logic [1:0] {
    lo_off    = 2'b00,
    lo_save   = 2'b01,
    lo_active = 2'b10
  } lineout_state_e;

  // path and power control as written by the host
  typedef struct packed {
    logic       beep_power_ctl;
    logic       beep_to_speaker_sel;
    logic       beep_to_lineout_sel;
    logic       dac_to_lineout_sel;
    logic       lineout_power_ctl;
    logic       lineout_save_ctl;
    logic [1:0] speaker_gain_field;
  } out_ctl_s;

  // resulting analog controls
  typedef struct packed {
    logic           beep_powered;
    logic           beep_to_speaker;
    logic           beep_to_lineout;
    logic           dac_to_lineout;
    logic           dac_to_speaker;
    lineout_state_e lineout_state;
    logic [3:0]     speaker_gain_db;
  } out_drive_s;

endpackage

/* soft_mute_ramp.sv */
// soft mute attenuation ramp, one step per sample enable
// assumes fs_en is a one-cycle pulse per sample period
`include "playback_mute_output_defs.svh"

module soft_mute_ramp #(
  parameter int RAMP_STEPS = `MUTE_RAMP_FS
) (
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   fs_en,
  input  wire logic                   soft_mute_ctl,
  output logic [`MUTE_ATT_W-1:0]      att_r
);

  // unity code equals the ramp length: one step a sample spans it
  localparam logic [`MUTE_ATT_W-1:0] ATT_UNITY = `MUTE_ATT_W'(RAMP_STEPS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      att_r <= ATT_UNITY;
    end else if (fs_en) begin
      // reversal mid-ramp simply turns the direction: same time back
      if (soft_mute_ctl && att_r != `MUTE_ATT_ZERO) begin
        att_r <= att_r - 8'h01; // R01 R04
      end else if (!soft_mute_ctl && att_r != ATT_UNITY) begin
        att_r <= att_r + 8'h01; // R02 R03 R04
      end
    end
  end

  // nrst in the antecedents: the release edge still loads reset values
  AST_RAMP_DOWN: assert property (@(posedge clk) disable iff (!nrst) // R01
    nrst && fs_en && soft_mute_ctl && att_r != `MUTE_ATT_ZERO
      |=> att_r == $past(att_r) - 8'h01)
    else $error("mute ramp did not step down");

  AST_RAMP_UP: assert property (@(posedge clk) disable iff (!nrst) // R02
    nrst && fs_en && !soft_mute_ctl && att_r != ATT_UNITY
      |=> att_r == $past(att_r) + 8'h01)
    else $error("mute ramp did not step up");

  AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (!nrst) // R04
    !fs_en |=> $stable(att_r))
    else $error("mute attenuation moved off a sample");

  AST_RAMP_BOUND: assert property (@(posedge clk) disable iff (!nrst) // R03
    att_r <= ATT_UNITY)
    else $error("mute attenuation out of range");

endmodule
